// >>> vid_phase_pkg.sv
package vid_phase_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int ON_TIME_NS = 300;
    localparam int ON_TIME_CYC = (ON_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Voltage code scale: one code step is 8 fine units
    localparam logic [6:0] VID_FULL_SCALE = 7'h78;
    localparam int FINE_SHIFT = 3;
    localparam logic [3:0] STEP_NOMINAL = 4'h8;
    localparam logic [3:0] STEP_HALF = 4'h4;
    localparam logic [3:0] STEP_EIGHTH = 4'h1;

    // Register offsets
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_INT_STATUS = 12'h008;
    localparam logic [11:0] ADDR_INT_MASK = 12'h00C;

    // Field positions
    localparam int CTRL_BOOT_LSB = 0;
    localparam int CTRL_PERIOD_LSB = 8;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_PGOOD = 3;
    localparam int STAT_OVERLAP = 4;
    localparam int STAT_PHASE2 = 5;
    localparam int STAT_SKIP = 6;
    localparam int STAT_SETTLED = 7;
    localparam int STAT_TARGET_LSB = 16;
    localparam int INT_FAULT = 0;
    localparam int INT_PGOOD_RISE = 1;
    localparam int INT_PGOOD_FALL = 2;
    localparam int INT_SHUTDOWN_DONE = 3;

    // Reset values
    localparam logic [6:0] BOOT_CODE_RST = 7'h30;
    localparam logic [7:0] SLEW_PERIOD_RST = 8'h0A;
    localparam logic [3:0] INT_MASK_RST = 4'h0;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_STARTUP = 3'b001,
        ST_RUN = 3'b011,
        ST_SOFTSTOP = 3'b010,
        ST_FAULT = 3'b110
    } reg_state_t;

    typedef struct packed {
        logic regulator_enable_in;
        logic slow_exit_select;
        logic deep_sleep_select;
        logic light_load_phase_select_n;
        logic [6:0] vid_code_bits;
        logic undervoltage_protection;
        logic thermal_shutdown;
        logic output_above_regulation;
        logic min_off_expired;
        logic on_time_request;
        logic phase_imbalance;
        logic [7:0] ground_sense_offset;
    } pin_inputs_t;

    // Code n gives 1.5V minus n steps, floored at zero
    function automatic logic [10:0] vid_to_fine(input logic [6:0] code);
        logic [6:0] steps;
        steps = VID_FULL_SCALE - code;
        if (code >= VID_FULL_SCALE) begin
            return 11'h000;
        end
        return {1'b0, steps, 3'b000};
    endfunction

endpackage

// >>> pin_sync.sv
`timescale 1ns/1ns
module pin_sync
    import vid_phase_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire pin_inputs_t pins_async,
    output pin_inputs_t pins_sync
);
    pin_inputs_t stage1;

    // Two flip-flops before any logic reads a pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            pins_sync <= '0;
        end else begin
            stage1 <= pins_async;
            pins_sync <= stage1;
        end
    end
endmodule

// >>> slew_ramp.sv
`timescale 1ns/1ns
module slew_ramp
    import vid_phase_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clear,
    input wire logic [10:0] goal,
    input wire logic [3:0] step,
    input wire logic [7:0] period,
    // Ramp state
    output logic [10:0] value,
    output logic settled,
    output logic downward
);
    logic [7:0] tick_cnt;
    logic [7:0] next_tick_cnt;
    logic [10:0] next_value;
    logic [10:0] diff;

    always_comb begin
        next_tick_cnt = tick_cnt + 8'h01;
        next_value = value;
        diff = 11'h000;
        if (clear) begin
            next_value = 11'h000;
            next_tick_cnt = 8'h00;
        end else if (tick_cnt >= period) begin
            next_tick_cnt = 8'h00;
            if (value < goal) begin
                diff = goal - value;
                next_value = (diff > {7'h00, step}) ? value + {7'h00, step} : goal;
            end else if (value > goal) begin
                diff = value - goal;
                next_value = (diff > {7'h00, step}) ? value - {7'h00, step} : goal;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 8'h00;
            value <= 11'h000;
        end else begin
            tick_cnt <= next_tick_cnt;
            value <= next_value;
        end
    end

    assign settled = (value == goal);
    assign downward = (value > goal);
endmodule

// >>> vid_mode_phase_control.sv
`timescale 1ns/1ns
// Function
// - Output low at end of minimum off-time: next on-time fires both high sides.
// - Overlap lasts until output is above regulation at a minimum off-time end.
// - After overlap, alternation resumes with the phase opposite the last pre-overlap pulse.
// - Target equals code reference plus remote ground-sense offset.
// - Startup ramps the internal target from zero to the boot level.
// - Seven-bit code sets target; any code change starts a slewed transition.
// - Enable low keeps the controller disabled with both low-side gates low.
// - Enable rising starts all phases pulse-skipping at one-eighth slew to boot.
// - Full power: all phases forced-PWM, nominal slew, tracking the code.
// - Phase-select low disables phase 2 gates; phase 1 forced-PWM, nominal slew.
// - Deep sleep forces single-phase pulse-skipping, ignores phase-select, phase 2 off.
// - Deep sleep blanks upper power-good and clock-enable thresholds on downward moves.
// - Deep sleep with slow-exit low halves slew and blanks upper thresholds.
// - Enable falling: drop good flags, clock-enable high, forced-PWM eighth slew to 0V.
// - Undervoltage or thermal fault latches off until supply cycle or enable toggle.
// - Off code runs shutdown; leaving it runs startup; off code at enable stays off.
module vid_mode_phase_control
    import vid_phase_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device pins
    input wire pin_inputs_t pins_in,
    // Gate drives
    output logic high_side_gate_1,
    output logic high_side_gate_2,
    output logic low_side_gate_1,
    output logic low_side_gate_2,
    // Status pins
    output logic output_in_regulation,
    output logic phase_balance_ok,
    output logic clock_gen_enable_n,
    output logic pulse_skip_mode,
    output logic [11:0] target_voltage,
    output logic irq
);
    pin_inputs_t pins;
    reg_state_t state;
    reg_state_t next_state;

    // Edge history
    logic en_prev;
    logic min_off_prev;
    logic on_req_prev;
    logic en_fall;
    logic min_off_rise;
    logic on_req_rise;
    logic fault_evt;
    logic off_code;

    // Ramp
    logic ramp_clear;
    logic [10:0] ramp_goal;
    logic [3:0] ramp_step;
    logic [10:0] ramp_value;
    logic ramp_settled;
    logic ramp_down;

    // Mode and phase state
    logic phase2_active;
    logic next_phase2_active;
    logic next_pulse_skip;
    logic gates_on;
    logic overlap;
    logic next_overlap;
    logic last_phase;
    logic next_last_phase;
    logic [3:0] on_cnt;
    logic [3:0] next_on_cnt;
    logic next_hs1;
    logic next_hs2;
    logic next_ls1;
    logic next_ls2;
    logic next_pgood;
    logic next_phase_ok;
    logic [11:0] next_target;
    logic [12:0] target_sum;

    // Registers
    logic [6:0] boot_code;
    logic [7:0] slew_period;
    logic [3:0] int_status;
    logic [3:0] int_mask;
    logic [6:0] next_boot_code;
    logic [7:0] next_slew_period;
    logic [3:0] next_int_status;
    logic [3:0] next_int_mask;
    logic [3:0] events;
    logic next_irq;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic wr_en;
    logic rd_phase;
    logic addr_ok;

    pin_sync u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pins_async(pins_in),
        .pins_sync(pins)
    );

    slew_ramp u_slew_ramp (
        .pclk(pclk),
        .presetn(presetn),
        .clear(ramp_clear),
        .goal(ramp_goal),
        .step(ramp_step),
        .period(slew_period),
        .value(ramp_value),
        .settled(ramp_settled),
        .downward(ramp_down)
    );

    assign en_fall = en_prev & ~pins.regulator_enable_in;
    assign min_off_rise = pins.min_off_expired & ~min_off_prev;
    assign on_req_rise = pins.on_time_request & ~on_req_prev;
    assign fault_evt = pins.undervoltage_protection | pins.thermal_shutdown;
    assign off_code = (pins.vid_code_bits >= VID_FULL_SCALE);

    // Mode sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF: begin
                if (pins.regulator_enable_in && !off_code) begin
                    next_state = ST_STARTUP;
                end
            end
            ST_STARTUP: begin
                if (!pins.regulator_enable_in || en_fall) begin
                    next_state = ST_SOFTSTOP;
                end else if (fault_evt) begin
                    next_state = ST_FAULT;
                end else if (off_code) begin
                    next_state = ST_SOFTSTOP;
                end else if (ramp_settled) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!pins.regulator_enable_in) begin
                    next_state = ST_SOFTSTOP;
                end else if (fault_evt) begin
                    next_state = ST_FAULT;
                end else if (off_code) begin
                    next_state = ST_SOFTSTOP;
                end
            end
            ST_SOFTSTOP: begin
                if (fault_evt) begin
                    next_state = ST_FAULT;
                end else if (ramp_value == 11'h000) begin
                    next_state = ST_OFF;
                end
            end
            ST_FAULT: begin
                if (!pins.regulator_enable_in) begin
                    next_state = ST_OFF;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    // Ramp goal and slew rate per mode
    always_comb begin
        ramp_clear = (state == ST_OFF) || (state == ST_FAULT);
        ramp_goal = 11'h000;
        ramp_step = STEP_NOMINAL;
        unique case (state)
            ST_STARTUP: begin
                ramp_goal = vid_to_fine(boot_code);
                ramp_step = STEP_EIGHTH;
            end
            ST_RUN: begin
                ramp_goal = vid_to_fine(pins.vid_code_bits);
                if (off_code) begin
                    ramp_step = STEP_EIGHTH;
                end else if (pins.deep_sleep_select && !pins.slow_exit_select) begin
                    ramp_step = STEP_HALF;
                end else begin
                    ramp_step = STEP_NOMINAL;
                end
            end
            ST_SOFTSTOP: begin
                ramp_goal = 11'h000;
                ramp_step = STEP_EIGHTH;
            end
            default: begin
                ramp_goal = 11'h000;
            end
        endcase
    end

    // Phase selection and operating mode
    always_comb begin
        gates_on = (next_state == ST_STARTUP) || (next_state == ST_RUN) || (next_state == ST_SOFTSTOP);
        next_phase2_active = gates_on;
        next_pulse_skip = 1'b0;
        if (next_state == ST_STARTUP) begin
            next_pulse_skip = 1'b1;
        end else if (next_state == ST_RUN) begin
            if (pins.deep_sleep_select) begin
                next_pulse_skip = 1'b1;
                next_phase2_active = 1'b0;
            end else if (!pins.light_load_phase_select_n) begin
                next_phase2_active = 1'b0;
            end
        end
    end

    // On-time pulses with transient overlap
    always_comb begin
        next_overlap = overlap;
        next_last_phase = last_phase;
        next_on_cnt = (on_cnt != 4'h0) ? on_cnt - 4'h1 : 4'h0;
        next_hs1 = high_side_gate_1 && (on_cnt > 4'h1);
        next_hs2 = high_side_gate_2 && (on_cnt > 4'h1);
        if (!gates_on || !next_phase2_active) begin
            next_overlap = 1'b0;
        end else if (min_off_rise) begin
            next_overlap = !pins.output_above_regulation;
        end
        if (gates_on && on_req_rise && on_cnt == 4'h0) begin
            next_on_cnt = 4'(ON_TIME_CYC);
            if (overlap && next_phase2_active) begin
                next_hs1 = 1'b1;
                next_hs2 = 1'b1;
            end else if (!next_phase2_active) begin
                next_hs1 = 1'b1;
                next_last_phase = 1'b0;
            end else begin
                next_hs1 = last_phase;
                next_hs2 = !last_phase;
                next_last_phase = !last_phase;
            end
        end
        if (!gates_on) begin
            next_hs1 = 1'b0;
            next_hs2 = 1'b0;
            next_on_cnt = 4'h0;
        end
        if (!next_phase2_active) begin
            next_hs2 = 1'b0;
        end
        next_ls1 = gates_on && !next_hs1;
        next_ls2 = gates_on && next_phase2_active && !next_hs2;
    end

    // Good flags and target
    always_comb begin
        next_pgood = (next_state == ST_RUN) &&
                     (ramp_settled || (pins.deep_sleep_select && ramp_down));
        next_phase_ok = (next_state == ST_RUN) && !pins.phase_imbalance;
        target_sum = {2'b00, ramp_value} + {{5{pins.ground_sense_offset[7]}}, pins.ground_sense_offset};
        if (target_sum[12]) begin
            next_target = 12'h000;
        end else begin
            next_target = target_sum[11:0];
        end
    end

    // APB decode and register updates
    always_comb begin
        rd_phase = psel && penable && !pready;
        wr_en = psel && penable && pready && pwrite;
        addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                  (paddr == ADDR_INT_STATUS) || (paddr == ADDR_INT_MASK);
        next_pready = rd_phase;
        next_pslverr = rd_phase && !addr_ok;
        next_prdata = 32'h0000_0000;
        if (rd_phase && !pwrite) begin
            unique case (paddr)
                ADDR_CTRL: begin
                    next_prdata[CTRL_BOOT_LSB +: 7] = boot_code;
                    next_prdata[CTRL_PERIOD_LSB +: 8] = slew_period;
                end
                ADDR_STATUS: begin
                    next_prdata[STAT_STATE_LSB +: 3] = state;
                    next_prdata[STAT_PGOOD] = output_in_regulation;
                    next_prdata[STAT_OVERLAP] = overlap;
                    next_prdata[STAT_PHASE2] = phase2_active;
                    next_prdata[STAT_SKIP] = pulse_skip_mode;
                    next_prdata[STAT_SETTLED] = ramp_settled;
                    next_prdata[STAT_TARGET_LSB +: 12] = target_voltage;
                end
                ADDR_INT_STATUS: begin
                    next_prdata[3:0] = int_status;
                end
                ADDR_INT_MASK: begin
                    next_prdata[3:0] = int_mask;
                end
                default: begin
                    next_prdata = 32'h0000_0000;
                end
            endcase
        end
        next_boot_code = boot_code;
        next_slew_period = slew_period;
        next_int_mask = int_mask;
        if (wr_en && paddr == ADDR_CTRL) begin
            next_boot_code = pwdata[CTRL_BOOT_LSB +: 7];
            next_slew_period = pwdata[CTRL_PERIOD_LSB +: 8];
        end
        if (wr_en && paddr == ADDR_INT_MASK) begin
            next_int_mask = pwdata[3:0];
        end
        events = 4'h0;
        events[INT_FAULT] = (next_state == ST_FAULT) && (state != ST_FAULT);
        events[INT_PGOOD_RISE] = next_pgood && !output_in_regulation;
        events[INT_PGOOD_FALL] = !next_pgood && output_in_regulation;
        events[INT_SHUTDOWN_DONE] = (state == ST_SOFTSTOP) && (next_state == ST_OFF);
        next_int_status = int_status;
        if (wr_en && paddr == ADDR_INT_STATUS) begin
            next_int_status = int_status & ~pwdata[3:0];
        end
        next_int_status = next_int_status | events;
        next_irq = |(next_int_status & next_int_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_OFF;
            en_prev <= 1'b0;
            min_off_prev <= 1'b0;
            on_req_prev <= 1'b0;
            phase2_active <= 1'b0;
            pulse_skip_mode <= 1'b0;
            overlap <= 1'b0;
            last_phase <= 1'b1;
            on_cnt <= 4'h0;
            high_side_gate_1 <= 1'b0;
            high_side_gate_2 <= 1'b0;
            low_side_gate_1 <= 1'b0;
            low_side_gate_2 <= 1'b0;
            output_in_regulation <= 1'b0;
            phase_balance_ok <= 1'b0;
            clock_gen_enable_n <= 1'b1;
            target_voltage <= 12'h000;
            boot_code <= BOOT_CODE_RST;
            slew_period <= SLEW_PERIOD_RST;
            int_status <= 4'h0;
            int_mask <= INT_MASK_RST;
            irq <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
            en_prev <= pins.regulator_enable_in;
            min_off_prev <= pins.min_off_expired;
            on_req_prev <= pins.on_time_request;
            phase2_active <= next_phase2_active;
            pulse_skip_mode <= next_pulse_skip;
            overlap <= next_overlap;
            last_phase <= next_last_phase;
            on_cnt <= next_on_cnt;
            high_side_gate_1 <= next_hs1;
            high_side_gate_2 <= next_hs2;
            low_side_gate_1 <= next_ls1;
            low_side_gate_2 <= next_ls2;
            output_in_regulation <= next_pgood;
            phase_balance_ok <= next_phase_ok;
            clock_gen_enable_n <= !next_pgood;
            target_voltage <= next_target;
            boot_code <= next_boot_code;
            slew_period <= next_slew_period;
            int_status <= next_int_status;
            int_mask <= next_int_mask;
            irq <= next_irq;
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end
endmodule

// >>> vid_phase_monitor.sv
`timescale 1ns/1ns
module vid_phase_monitor
    import vid_phase_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pins and outputs
    input wire pin_inputs_t pins_in,
    input wire logic high_side_gate_1,
    input wire logic high_side_gate_2,
    input wire logic low_side_gate_1,
    input wire logic low_side_gate_2,
    input wire logic output_in_regulation,
    input wire logic phase_balance_ok,
    input wire logic clock_gen_enable_n,
    input wire logic pulse_skip_mode,
    input wire logic [11:0] target_voltage
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic en = pins_in.regulator_enable_in;
    wire logic off_code = pins_in.vid_code_bits >= 7'h78;
    wire logic ph2_off = !high_side_gate_2 && !low_side_gate_2;
    wire logic all_off = ph2_off && !high_side_gate_1 && !low_side_gate_1 && !output_in_regulation;
    wire logic [3:0] mode = {en, pins_in.slow_exit_select, pins_in.deep_sleep_select,
        pins_in.light_load_phase_select_n};
    // Mode pins steady past the synchroniser while in regulation
    sequence running;
        $stable(mode) [*4] ##0 output_in_regulation;
    endsequence
    a_full_power: assert property (running ##0 mode == 4'b1101 |-> !pulse_skip_mode)
        else $error("pulse skipping in full power");
    a_phase2_dropped: assert property (running ##0 mode == 4'b1100 |-> ph2_off && !pulse_skip_mode)
        else $error("phase 2 active with phase select low");
    a_deep_single: assert property (running ##0 mode[3] && mode[1] |-> ph2_off && pulse_skip_mode)
        else $error("deep sleep not single phase skipping");
    a_disable_flags: assert property ($fell(en) |-> ##[1:4] !output_in_regulation && !phase_balance_ok && clock_gen_enable_n)
        else $error("good flags not dropped on disable");
    a_ramp_zero: assert property ($fell(en) |-> ##[1:1000] target_voltage == 12'h000)
        else $error("target not ramped to zero");
    a_clock_gen_enable_n_follow: assert property (running ##0 mode[1] &&
        target_voltage < $past(target_voltage) |=> !clock_gen_enable_n)
        else $error("clock enable dropped while slewing down in deep sleep");
    a_start_skip: assert property ($rose(en) && !off_code |-> ##[1:4] pulse_skip_mode)
        else $error("startup not pulse skipping");
    a_off_code_stop: assert property (en && $rose(off_code) |-> ##[1:4] !output_in_regulation)
        else $error("off code kept power good");
    a_fault_latch: assert property (en && $rose(pins_in.undervoltage_protection) |-> ##[1:4] all_off [*8])
        else $error("fault did not disable controller");
    a_low_sides_off: assert property ((!en && target_voltage == 12'h000) [*4] |-> !low_side_gate_1 && !low_side_gate_2)
        else $error("low side gate on while disabled");
endmodule

bind vid_mode_phase_control vid_phase_monitor mon (.pclk(pclk), .presetn(presetn), .pins_in(pins_in),
    .high_side_gate_1(high_side_gate_1), .high_side_gate_2(high_side_gate_2), .low_side_gate_1(low_side_gate_1),
    .low_side_gate_2(low_side_gate_2), .output_in_regulation(output_in_regulation),
    .phase_balance_ok(phase_balance_ok), .clock_gen_enable_n(clock_gen_enable_n),
    .pulse_skip_mode(pulse_skip_mode), .target_voltage(target_voltage));

// >>> cpu_pin_model.sv
`timescale 1ns/1ns
module cpu_pin_model
    import vid_phase_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Pins toward the regulator
    output pin_inputs_t pins
);
    initial begin
        pins = '0;
        pins.vid_code_bits = 7'h30;
    end
    // Enable, slow-exit, deep-sleep, phase-select, undervoltage, then thermal and imbalance
    task automatic drive(input logic [4:0] m, input logic [1:0] f = 2'b00);
        @(posedge pclk);
        {pins.regulator_enable_in, pins.slow_exit_select, pins.deep_sleep_select,
            pins.light_load_phase_select_n, pins.undervoltage_protection,
            pins.thermal_shutdown, pins.phase_imbalance} <= {m, f};
    endtask
    task automatic set_code(input logic [6:0] c, input logic [7:0] off);
        @(posedge pclk);
        pins.vid_code_bits <= c;
        pins.ground_sense_offset <= off;
    endtask
    // End of minimum off-time, then an on-time request
    task automatic fire(input logic above);
        @(posedge pclk);
        pins.output_above_regulation <= above;
        pins.min_off_expired <= 1'b1;
        pins.on_time_request <= 1'b0;
        repeat (3) @(posedge pclk);
        pins.min_off_expired <= 1'b0;
        pins.on_time_request <= 1'b1;
    endtask
endmodule

// >>> vid_mode_phase_control_tb_top.sv
`timescale 1ns/1ns
module vid_mode_phase_control_tb_top;
    import vid_phase_pkg::*;
    localparam logic [5:0] ABOVE = 6'b110011;
    localparam logic [11:0] FIRED = 12'h6F6;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic hs1, hs2, ls1, ls2, pg, pok, ckn, skip;
    logic [11:0] paddr, target;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] fired;
    pin_inputs_t pins;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    cpu_pin_model cpu (.pclk(pclk), .pins(pins));
    vid_mode_phase_control dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins),
        .high_side_gate_1(hs1), .high_side_gate_2(hs2), .low_side_gate_1(ls1), .low_side_gate_2(ls2),
        .output_in_regulation(pg), .phase_balance_ok(pok), .clock_gen_enable_n(ckn), .pulse_skip_mode(skip),
        .target_voltage(target), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            fail_count++;
            final_report;
        end
    end
    task automatic final_report;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd & m, exp);
    endtask
    task automatic wait_target(input logic [11:0] exp, input int lo, input int hi);
        int n;
        n = 0;
        while (target !== exp && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        check("target", target, exp);
        check("ramp cycles", n >= lo && n <= hi, 1);
    endtask
    task automatic fire_chk(input logic above, input logic [1:0] exp);
        fired = 2'b00;
        cpu.fire(above);
        repeat (7) begin
            @(posedge pclk);
            fired = fired | {hs2, hs1};
        end
        check("high sides", fired, exp);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("ctrl", ADDR_CTRL, 32'h0000_FF7F, 32'h0000_0A30);
        apb(1'b1, 12'h010, 32'h0);
        check("slverr", err, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h0000_0030);
        cpu.drive(5'b11010);
        wait_target(12'd576, 577, 584);
        rdchk("state", ADDR_STATUS, 32'h7, 32'h3);
        rdchk("pgood rise", ADDR_INT_STATUS, 32'h2, 32'h2);
        check("irq", irq, 1'b0);
        apb(1'b1, ADDR_INT_MASK, 32'h2);
        repeat (2) @(posedge pclk);
        check("irq", irq, 1'b1);
        apb(1'b1, ADDR_INT_STATUS, 32'h2);
        repeat (2) @(posedge pclk);
        check("irq", irq, 1'b0);
        cpu.set_code(7'h00, 8'h04);
        wait_target(12'd964, 49, 56);
        cpu.drive(5'b11010, 2'b01);
        repeat (4) @(posedge pclk);
        check("phase ok", pok, 1'b0);
        cpu.drive(5'b11010);
        for (int i = 0; i < 6; i++) begin
            fire_chk(ABOVE[5-i], FIRED[11-2*i -: 2]);
        end
        cpu.drive(5'b11000);
        fire_chk(1'b1, 2'b01);
        cpu.drive(5'b10100);
        repeat (5) @(posedge pclk);
        check("skip", skip, 1'b1);
        cpu.set_code(7'h08, 8'hFB);
        repeat (8) @(posedge pclk);
        check("pgood", pg, 1'b1);
        wait_target(12'd891, 9, 16);
        cpu.drive(5'b11100);
        cpu.set_code(7'h00, 8'h04);
        wait_target(12'd964, 9, 16);
        cpu.set_code(7'h7F, 8'h00);
        wait_target(12'd0, 961, 968);
        rdchk("off state", ADDR_STATUS, 32'h7, 32'h0);
        rdchk("stop done", ADDR_INT_STATUS, 32'h8, 32'h8);
        cpu.set_code(7'h30, 8'h00);
        wait_target(12'd576, 577, 584);
        cpu.drive(5'b11101);
        repeat (2) @(posedge pclk);
        cpu.drive(5'b11100);
        repeat (10) @(posedge pclk);
        rdchk("fault", ADDR_STATUS, 32'h7, 32'h6);
        cpu.drive(5'b01100);
        cpu.set_code(7'h7F, 8'h00);
        repeat (10) @(posedge pclk);
        cpu.drive(5'b11100);
        repeat (10) @(posedge pclk);
        rdchk("stay off", ADDR_STATUS, 32'h7, 32'h0);
        cpu.set_code(7'h30, 8'h00);
        wait_target(12'd576, 577, 584);
        cpu.drive(5'b01100);
        wait_target(12'd0, 577, 584);
        check("phase ok", pok, 1'b0);
        cpu.drive(5'b11100, 2'b10);
        repeat (12) @(posedge pclk);
        rdchk("thermal", ADDR_STATUS, 32'h7, 32'h6);
        final_report;
    end
endmodule
